// >>> mmct_regs.svh
// Register offsets, field positions, reset values and timing figures of the control block
`ifndef MMCT_REGS_SVH
`define MMCT_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define MMCT_OFF_STATUS 12'h000
`define MMCT_OFF_FLAGS 12'h004
`define MMCT_OFF_MASK 12'h008
`define MMCT_OFF_CONTROL 12'h00C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MMCT_ST_NOT_READY 0
`define MMCT_ST_READY 1
`define MMCT_ST_LOW_POWER 2
`define MMCT_ST_SERIAL_EN 3
`define MMCT_ST_LOS_LIVE 4
`define MMCT_ST_IRQ 5
`define MMCT_FL_INIT_DONE 0
`define MMCT_FL_LOS 1
`define MMCT_FL_FAULT_LSB 2
`define MMCT_CTL_PDOWN 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MMCT_RST_MASK 32'h0000_0000
`define MMCT_RST_CONTROL 1'b0
`define MMCT_RST_ZERO 32'h0000_0000
// Resting levels of the six single pins in the synchroniser, bit 0 first:
// reset, select, SCL and SDA rest high; low-power request and loss of signal rest low
`define MMCT_SYNC_IDLE 6'h1B

// ----------------------------------------------------------------
// Timing figures, in their printed units
// ----------------------------------------------------------------
`define MMCT_CLK_MHZ 200
`define MMCT_T_INIT_MS 2000
`define MMCT_T_RESET_MIN_US 2

// Cycle counts derived from the figures above
`define MMCT_INIT_MAX_CYC (`MMCT_T_INIT_MS * 1000 * `MMCT_CLK_MHZ)
`define MMCT_RESET_MIN_CYC (`MMCT_T_RESET_MIN_US * `MMCT_CLK_MHZ)

`endif

// >>> mmct_pkg.sv
// Types shared by the module management control block
`default_nettype none
package mmct_pkg;

  // ----------------------------------------------------------------
  // Life cycle of the module
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MMCT_HELD = 2'b00,
    MMCT_INIT = 2'b01,
    MMCT_READY = 2'b10
  } mmct_life_e;

  // ----------------------------------------------------------------
  // APB request as seen by the slave
  // ----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mmct_apb_req_s;

  // APB answer driven by the slave
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } mmct_apb_rsp_s;

endpackage
`default_nettype wire

// >>> mmct_ctrl.sv
// Module management control: init, reset filter, select, power, flags and interrupt
//
// Local design decisions: the address map and the APB interface to the registers.
`default_nettype none
`include "mmct_regs.svh"

// Notes on behaviour
// RULE1 - Fully functional within 2000 ms after reset
// RULE2 - Reset counts only if low over 2 us
// RULE3 - Serial bus answers within 2000 ms of power
// RULE4 - Clear not-ready bit and assert interrupt
// RULE5 - Functional again within 2000 ms of reset rise
// RULE6 - Low-power input drops power within 100 us
// RULE7 - Interrupt asserted within 200 ms of condition
// RULE8 - Interrupt released within 500 us of clear
// RULE9 - Loss of signal flagged within 100 ms
// RULE10 - Any flag set within 200 ms
// RULE11 - Setting mask inhibits interrupt within 100 ms
// RULE12 - Clearing mask resumes interrupt within 100 ms
// RULE13 - Selected module answers bus within 100 us
// RULE14 - Deselected module stops answering within 100 us
// RULE15 - Power-down bit lowers power within 100 ms
// RULE16 - Clearing power-down restores function within 300 ms
// RULE17 - Fully functional means ready interrupt raised
// RULE18 - Mask and power-down timed from post-stop SCL fall
// RULE19 - Release timed from post-stop SCL fall
// RULE20 - Interrupt low while any unmasked flag set
module mmct_ctrl
  import mmct_pkg::*;
#(
  parameter int unsigned NUM_FAULTS = 2,
  parameter int unsigned INIT_WAIT_CYC = `MMCT_INIT_MAX_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // APB slave
  input wire mmct_apb_req_s apb_req_in,
  output var mmct_apb_rsp_s apb_rsp_out,
  // Control pins from the host
  input wire logic module_reset_n_in,
  input wire logic module_select_n_in,
  input wire logic low_power_request_in,
  // Serial management bus pins, observed only
  input wire logic scl_in,
  input wire logic sda_in,
  // Conditions from the receiver
  input wire logic los_in,
  input wire logic [NUM_FAULTS-1:0] fault_in,
  // Status outputs
  output logic interrupt_out_n_out,
  output logic low_power_out,
  output logic serial_enable_out,
  output logic module_ready_out
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  localparam int unsigned NFLAGS = NUM_FAULTS + `MMCT_FL_FAULT_LSB;
  localparam int unsigned NSYNC = NUM_FAULTS + 6;
  // Stages start at each pin's resting level, so reset sets no flag and fakes no edge
  localparam logic [NSYNC-1:0] SYNC_IDLE = {{NUM_FAULTS{1'b0}}, `MMCT_SYNC_IDLE};

  initial begin
    if (NUM_FAULTS < 1 || NFLAGS > 32) begin
      $error("NUM_FAULTS too large for one flag word");
    end
    if (INIT_WAIT_CYC < 1 || INIT_WAIT_CYC > `MMCT_INIT_MAX_CYC) begin
      $error("INIT_WAIT_CYC outside the allowed init time");
    end
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  logic [NSYNC-1:0] sync3_ff;
  logic [NSYNC-1:0] clean_ff;

  assign raw_in = {fault_in, los_in, sda_in, scl_in, low_power_request_in,
                   module_select_n_in, module_reset_n_in};

  // Three stages; a value counts only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          sync1_ff[gi] <= SYNC_IDLE[gi];
          sync2_ff[gi] <= SYNC_IDLE[gi];
          sync3_ff[gi] <= SYNC_IDLE[gi];
          clean_ff[gi] <= SYNC_IDLE[gi];
        end else begin
          sync1_ff[gi] <= raw_in[gi];
          sync2_ff[gi] <= sync1_ff[gi];
          sync3_ff[gi] <= sync2_ff[gi];
          if (sync2_ff[gi] == sync3_ff[gi]) begin
            clean_ff[gi] <= sync3_ff[gi];
          end
        end
      end
    end
  endgenerate

  logic rst_pin_n;
  logic sel_pin_n;
  logic lp_pin;
  logic scl_s;
  logic sda_s;
  logic los_s;
  logic [NUM_FAULTS-1:0] fault_s;

  assign rst_pin_n = clean_ff[0];
  assign sel_pin_n = clean_ff[1];
  assign lp_pin = clean_ff[2];
  assign scl_s = clean_ff[3];
  assign sda_s = clean_ff[4];
  assign los_s = clean_ff[5];
  assign fault_s = clean_ff[NSYNC-1:6];

  // ----------------------------------------------------------------
  // Serial bus stop detection and commit point
  // ----------------------------------------------------------------
  logic scl_d_ff;
  logic sda_d_ff;
  logic stop_seen_ff;
  logic commit_ff;
  logic scl_fall;
  logic stop_cond;

  assign scl_fall = scl_d_ff & ~scl_s;
  assign stop_cond = scl_s & scl_d_ff & sda_s & ~sda_d_ff;

  // Commit fires on the first SCL fall after a stop condition
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      stop_seen_ff <= 1'b0;
      commit_ff <= 1'b0;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      commit_ff <= stop_seen_ff & scl_fall; // RULE18 RULE19
      if (stop_cond) begin
        stop_seen_ff <= 1'b1;
      end else if (scl_fall) begin
        stop_seen_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset pin filter
  // ----------------------------------------------------------------
  logic [15:0] rst_cnt_ff;
  logic rst_valid_ff;

  // Glitches shorter than the minimum pulse are ignored on purpose
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_cnt_ff <= '0;
      rst_valid_ff <= 1'b0;
    end else if (rst_pin_n) begin
      rst_cnt_ff <= '0;
      rst_valid_ff <= 1'b0;
    end else if (rst_cnt_ff > 16'(`MMCT_RESET_MIN_CYC)) begin
      rst_valid_ff <= 1'b1; // RULE2
    end else begin
      rst_cnt_ff <= rst_cnt_ff + 16'd1;
    end
  end

  // ----------------------------------------------------------------
  // Life cycle: held, initialising, ready
  // ----------------------------------------------------------------
  mmct_life_e life_ff;
  logic [31:0] init_cnt_ff;
  logic ready_event;

  assign ready_event = (life_ff == MMCT_INIT) && (init_cnt_ff == INIT_WAIT_CYC - 1);

  // Async reset stands for power on; a filtered pin reset reruns init
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      life_ff <= MMCT_INIT;
      init_cnt_ff <= '0;
    end else if (rst_valid_ff) begin
      life_ff <= MMCT_HELD;
      init_cnt_ff <= '0;
    end else begin
      unique case (life_ff)
        MMCT_HELD: begin
          life_ff <= MMCT_INIT; // RULE5
        end
        MMCT_INIT: begin
          init_cnt_ff <= init_cnt_ff + 32'd1;
          if (ready_event) begin
            life_ff <= MMCT_READY; // RULE1 RULE3
          end
        end
        MMCT_READY: begin
          init_cnt_ff <= '0;
        end
        default: begin
          life_ff <= MMCT_HELD;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic setup;
  logic access;
  logic wr_mask;
  logic wr_ctl;
  logic rd_flags;
  logic [31:0] mask_ff;
  logic pdown_ff;
  logic [31:0] flags_ff;
  logic [31:0] status;
  logic [31:0] rdata;
  logic known;

  assign setup = apb_req_in.psel & ~apb_req_in.penable;
  assign access = apb_req_in.psel & apb_req_in.penable & apb_rsp_out.pready;
  assign wr_mask = access & apb_req_in.pwrite & (apb_req_in.paddr == `MMCT_OFF_MASK);
  assign wr_ctl = access & apb_req_in.pwrite & (apb_req_in.paddr == `MMCT_OFF_CONTROL);
  assign rd_flags = access & ~apb_req_in.pwrite & (apb_req_in.paddr == `MMCT_OFF_FLAGS);

  // Live status word
  always_comb begin
    status = `MMCT_RST_ZERO;
    status[`MMCT_ST_NOT_READY] = (life_ff != MMCT_READY); // RULE4
    status[`MMCT_ST_READY] = (life_ff == MMCT_READY);
    status[`MMCT_ST_LOW_POWER] = low_power_out;
    status[`MMCT_ST_SERIAL_EN] = serial_enable_out;
    status[`MMCT_ST_LOS_LIVE] = los_s;
    status[`MMCT_ST_IRQ] = ~interrupt_out_n_out;
  end

  // Read mux, unmapped addresses answer an error
  always_comb begin
    rdata = `MMCT_RST_ZERO;
    known = 1'b1;
    unique case (apb_req_in.paddr)
      `MMCT_OFF_STATUS: rdata = status;
      `MMCT_OFF_FLAGS: rdata = flags_ff;
      `MMCT_OFF_MASK: rdata = mask_ff;
      `MMCT_OFF_CONTROL: rdata[`MMCT_CTL_PDOWN] = pdown_ff;
      default: known = 1'b0;
    endcase
  end

  // Answer prepared in setup, so the access phase has no wait state
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      apb_rsp_out <= '0;
    end else if (setup) begin
      apb_rsp_out.pready <= 1'b1;
      apb_rsp_out.pslverr <= ~known;
      apb_rsp_out.prdata <= apb_req_in.pwrite ? `MMCT_RST_ZERO : rdata;
    end else begin
      apb_rsp_out <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Staged writes and clears, applied at the serial commit point
  // ----------------------------------------------------------------
  logic [31:0] mask_pend_ff;
  logic mask_pend_v_ff;
  logic pdown_pend_ff;
  logic pdown_pend_v_ff;
  logic [31:0] clr_pend_ff;

  // A second write before the commit replaces the first
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mask_pend_ff <= `MMCT_RST_MASK;
      mask_pend_v_ff <= 1'b0;
      mask_ff <= `MMCT_RST_MASK;
    end else begin
      if (wr_mask) begin
        mask_pend_ff <= apb_req_in.pwdata;
        mask_pend_v_ff <= 1'b1;
      end else if (commit_ff) begin
        mask_pend_v_ff <= 1'b0;
      end
      if (commit_ff && mask_pend_v_ff) begin
        mask_ff <= mask_pend_ff; // RULE11 RULE12 RULE18
      end
    end
  end

  // Power-down bit, staged the same way
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pdown_pend_ff <= `MMCT_RST_CONTROL;
      pdown_pend_v_ff <= 1'b0;
      pdown_ff <= `MMCT_RST_CONTROL;
    end else begin
      if (wr_ctl) begin
        pdown_pend_ff <= apb_req_in.pwdata[`MMCT_CTL_PDOWN];
        pdown_pend_v_ff <= 1'b1;
      end else if (commit_ff) begin
        pdown_pend_v_ff <= 1'b0;
      end
      if (commit_ff && pdown_pend_v_ff) begin
        pdown_ff <= pdown_pend_ff; // RULE15 RULE16 RULE18
      end
    end
  end

  // Only bits actually returned by a read are queued for clearing
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clr_pend_ff <= `MMCT_RST_ZERO;
    end else if (rd_flags) begin
      // Bits applied by a commit in this cycle are dropped, never cleared twice
      clr_pend_ff <= (commit_ff ? `MMCT_RST_ZERO : clr_pend_ff) | apb_rsp_out.prdata;
    end else if (commit_ff) begin
      clr_pend_ff <= `MMCT_RST_ZERO; // RULE19
    end
  end

  // ----------------------------------------------------------------
  // Latched flags
  // ----------------------------------------------------------------
  logic [31:0] flag_set;

  always_comb begin
    flag_set = `MMCT_RST_ZERO;
    flag_set[`MMCT_FL_INIT_DONE] = ready_event; // RULE4 RULE17
    flag_set[`MMCT_FL_LOS] = los_s; // RULE9
    flag_set[NFLAGS-1:`MMCT_FL_FAULT_LSB] = fault_s; // RULE10
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flags_ff <= `MMCT_RST_ZERO;
    end else begin
      flags_ff <= (flags_ff & ~(commit_ff ? clr_pend_ff : `MMCT_RST_ZERO)) | flag_set; // RULE8
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  // Interrupt follows the unmasked flags one cycle later
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      interrupt_out_n_out <= 1'b1;
    end else begin
      interrupt_out_n_out <= ~|(flags_ff & ~mask_ff); // RULE7 RULE20
    end
  end

  // Either the pin or the register forces low power
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      low_power_out <= 1'b0;
    end else begin
      low_power_out <= lp_pin | pdown_ff; // RULE6 RULE15 RULE16
    end
  end

  // Serial bus answers only when ready and selected
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      serial_enable_out <= 1'b0;
      module_ready_out <= 1'b0;
    end else begin
      serial_enable_out <= (life_ff == MMCT_READY) & ~sel_pin_n; // RULE3 RULE13 RULE14
      module_ready_out <= (life_ff == MMCT_READY);
    end
  end

endmodule
`default_nettype wire

// >>> mmct_ctrl_assertions.sv
// Timing checks of the management control block, bound to its ports
`default_nettype none
module mmct_ctrl_assertions
  import mmct_pkg::*;
#(
  parameter int unsigned NUM_FAULTS = 2,
  parameter int unsigned INIT_WAIT_CYC = 50
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Bus and pins
  input wire mmct_apb_req_s apb_req_in,
  input wire mmct_apb_rsp_s apb_rsp_out,
  input wire logic module_reset_n_in,
  input wire logic module_select_n_in,
  input wire logic low_power_request_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic los_in,
  input wire logic [NUM_FAULTS-1:0] fault_in,
  // Status
  input wire logic interrupt_out_n_out,
  input wire logic low_power_out,
  input wire logic serial_enable_out,
  input wire logic module_ready_out
);
  logic [31:0] init_cyc_ff;
  logic [9:0] rlow_ff;
  logic [7:0] scl_age_ff;
  logic scl_d_ff;
  // Not-ready time; held reset or low power excuse it
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) init_cyc_ff <= 32'h0000_0000;
    else if (module_ready_out || !module_reset_n_in || low_power_out) init_cyc_ff <= '0;
    else init_cyc_ff <= init_cyc_ff + 32'h0000_0001;
  end
  // Length of the current low pulse on the reset pin
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) rlow_ff <= 10'h000;
    else if (module_reset_n_in) rlow_ff <= 10'h000;
    else if (rlow_ff != 10'h3FF) rlow_ff <= rlow_ff + 10'h001;
  end
  // Age of the last SCL fall, saturating so idle time never wraps
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scl_d_ff <= 1'b1;
      scl_age_ff <= 8'hFF;
    end else begin
      scl_d_ff <= scl_in;
      if (scl_d_ff && !scl_in) scl_age_ff <= 8'h00;
      else if (scl_age_ff != 8'hFF) scl_age_ff <= scl_age_ff + 8'h01;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  a_apb_zero_wait: assert property (apb_req_in.psel && !apb_req_in.penable |=>
    apb_rsp_out.pready) else $error("no ready in access cycle");
  a_init_bound: assert property (init_cyc_ff <= INIT_WAIT_CYC + 16)
    else $error("module not ready in time");
  a_ready_irq: assert property ($rose(module_ready_out) && init_cyc_ff > INIT_WAIT_CYC / 2
    |-> ##[0:3] !interrupt_out_n_out) else $error("no interrupt at ready");
  a_los_irq: assert property ($rose(los_in) |-> ##[1:10] !interrupt_out_n_out)
    else $error("loss of signal not flagged");
  a_lp_pin: assert property ($rose(low_power_request_in) |-> ##[1:8] low_power_out)
    else $error("low power pin ignored");
  a_sel_on: assert property ((!module_select_n_in && module_ready_out) [*8]
    |-> serial_enable_out) else $error("selected but serial bus off");
  a_sel_off: assert property (module_select_n_in [*8] |-> !serial_enable_out)
    else $error("deselected but serial bus on");
  a_pdown_commit: assert property ($rose(low_power_out) && !low_power_request_in
    |-> scl_age_ff < 8'h10) else $error("power down outside commit");
  a_irq_release: assert property ($rose(interrupt_out_n_out) && module_ready_out
    |-> scl_age_ff < 8'h10) else $error("interrupt released outside commit");
  a_reset_filter: assert property ($fell(module_ready_out) && !low_power_out
    |-> rlow_ff > 10'h190) else $error("short reset pulse counted");
endmodule
bind mmct_ctrl mmct_ctrl_assertions #(.NUM_FAULTS(NUM_FAULTS), .INIT_WAIT_CYC(INIT_WAIT_CYC))
  u_chk (.clk_in(clk_in), .arst_n_in(arst_n_in), .apb_req_in(apb_req_in),
  .apb_rsp_out(apb_rsp_out), .module_reset_n_in(module_reset_n_in),
  .module_select_n_in(module_select_n_in), .low_power_request_in(low_power_request_in),
  .scl_in(scl_in), .sda_in(sda_in), .los_in(los_in), .fault_in(fault_in),
  .interrupt_out_n_out(interrupt_out_n_out), .low_power_out(low_power_out),
  .serial_enable_out(serial_enable_out), .module_ready_out(module_ready_out));
`default_nettype wire

// >>> mmct_host_model.sv
// Host model that frames a stop condition and the SCL fall after it
`default_nettype none
module mmct_host_model (
  // Trigger from the bench
  input wire logic go_in,
  // Serial bus pins, pulled up while idle
  output logic scl_out,
  output logic sda_out,
  output logic done_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pairs of SCL and SDA: start, bit, stop, start, fall, idle
  localparam logic [15:0] SEQ = 16'h8B87;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    done_out = 1'b1;
  end
  // Clock stands still between frames; offset keeps it off the bench clock phase
  always @(posedge go_in) begin
    done_out = 1'b0;
    #3.1;
    for (int i = 7; i >= 0; i--) begin
      {scl_out, sda_out} = SEQ[2*i+:2];
      #62.5;
    end
    done_out = 1'b1;
  end
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench of the management control block
`default_nettype none
`include "mmct_regs.svh"
module testbench
  import mmct_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned INIT = 50;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  mmct_apb_req_s req = '0;
  mmct_apb_rsp_s rsp;
  logic rst_n = 1'b1, sel_n = 1'b0, lp = 1'b0, los = 1'b0, go = 1'b0;
  logic [1:0] flt = 2'h0;
  logic scl, sda, done, irq_n, lpo, sen, rdy, e;
  logic [31:0] q;
  int err_count = 0;
  int check_count = 0;
  mmct_ctrl #(.NUM_FAULTS(2), .INIT_WAIT_CYC(INIT)) uut (.clk_in(clk_in),
    .arst_n_in(arst_n_in), .apb_req_in(req), .apb_rsp_out(rsp), .module_reset_n_in(rst_n),
    .module_select_n_in(sel_n), .low_power_request_in(lp), .scl_in(scl), .sda_in(sda),
    .los_in(los), .fault_in(flt), .interrupt_out_n_out(irq_n), .low_power_out(lpo),
    .serial_enable_out(sen), .module_ready_out(rdy));
  mmct_host_model host (.go_in(go), .scl_out(scl), .sda_out(sda), .done_out(done));
  // Free running 200 MHz clock
  always #2.5 clk_in = ~clk_in;
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // One APB transfer; request held until ready is seen high
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_in);
    req.penable <= 1'b1;
    @(posedge clk_in);
    while (rsp.pready !== 1'b1) @(posedge clk_in);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask
  // Staged writes and clears only land after a bus stop
  task automatic stop_frame();
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    @(posedge clk_in);
    while (done !== 1'b1) @(posedge clk_in);
    cyc(12);
  endtask
  task automatic clear_flags(input logic [31:0] exp);
    bus(1'b0, `MMCT_OFF_FLAGS, '0);
    ck(q, exp);
    stop_frame();
    ck(irq_n, 1'b1);
  endtask
  task automatic wait_ready();
    for (int i = 0; i < INIT + 40 && rdy !== 1'b1; i++) @(posedge clk_in);
    ck(rdy, 1'b1);
    cyc(4);
    ck(irq_n, 1'b0);
  endtask
  task automatic t_init();
    wait_ready();
    bus(1'b0, `MMCT_OFF_STATUS, '0);
    ck(q, 32'h0000_002A);
    bus(1'b0, `MMCT_OFF_FLAGS, '0);
    ck(q, 32'h0000_0001);
    cyc(20);
    ck(irq_n, 1'b0);
    stop_frame();
    ck(irq_n, 1'b1);
    $display("test init done");
  endtask
  task automatic t_regs();
    bus(1'b0, `MMCT_OFF_MASK, '0);
    ck(q, `MMCT_RST_MASK);
    bus(1'b0, `MMCT_OFF_CONTROL, '0);
    ck(q, `MMCT_RST_ZERO);
    bus(1'b1, 12'h010, 32'h0000_0001);
    ck(e, 1'b1);
    bus(1'b1, `MMCT_OFF_STATUS, 32'hFFFF_FFFF);
    bus(1'b0, `MMCT_OFF_STATUS, '0);
    ck(q, 32'h0000_000A);
    bus(1'b1, `MMCT_OFF_MASK, 32'h0000_0004);
    bus(1'b0, `MMCT_OFF_MASK, '0);
    ck(q, 32'h0000_0000);
    stop_frame();
    bus(1'b0, `MMCT_OFF_MASK, '0);
    ck(q, 32'h0000_0004);
    $display("test regs done");
  endtask
  task automatic t_mask();
    flt <= 2'h1;
    cyc(20);
    ck(irq_n, 1'b1);
    flt <= 2'h0;
    bus(1'b1, `MMCT_OFF_MASK, '0);
    stop_frame();
    ck(irq_n, 1'b0);
    clear_flags(32'h0000_0004);
    flt <= 2'h2;
    cyc(10);
    ck(irq_n, 1'b0);
    flt <= 2'h0;
    clear_flags(32'h0000_0008);
    $display("test mask done");
  endtask
  task automatic t_los();
    los <= 1'b1;
    cyc(10);
    ck(irq_n, 1'b0);
    bus(1'b0, `MMCT_OFF_STATUS, '0);
    ck(q, 32'h0000_003A);
    los <= 1'b0;
    clear_flags(32'h0000_0002);
    $display("test los done");
  endtask
  task automatic t_power();
    lp <= 1'b1;
    cyc(8);
    ck(lpo, 1'b1);
    lp <= 1'b0;
    cyc(8);
    bus(1'b1, `MMCT_OFF_CONTROL, 32'h0000_0001);
    cyc(10);
    ck(lpo, 1'b0);
    stop_frame();
    ck(lpo, 1'b1);
    bus(1'b1, `MMCT_OFF_CONTROL, '0);
    stop_frame();
    ck(lpo, 1'b0);
    ck(rdy, 1'b1);
    $display("test power done");
  endtask
  task automatic t_select();
    sel_n <= 1'b1;
    cyc(8);
    ck(sen, 1'b0);
    sel_n <= 1'b0;
    cyc(8);
    ck(sen, 1'b1);
    $display("test select done");
  endtask
  // Host keeps the counted reset pulse just over 2 us, at 450 cycles
  task automatic t_mreset();
    rst_n <= 1'b0;
    cyc(100);
    rst_n <= 1'b1;
    cyc(20);
    ck(rdy, 1'b1);
    rst_n <= 1'b0;
    cyc(450);
    ck(rdy, 1'b0);
    rst_n <= 1'b1;
    wait_ready();
    clear_flags(32'h0000_0001);
    $display("test module reset done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    cyc(8);
    arst_n_in <= 1'b1;
    t_init();
    t_regs();
    t_mask();
    t_los();
    t_power();
    t_select();
    t_mreset();
    end_of_test();
  end
  // Watchdog well beyond the expected run of some 1900 cycles
  initial begin
    #100us;
    err_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
